// ==== hw/sld_driver.v ====
// Summary of operation
// R1: rising shift clock captures serial input
// R2: each rising edge moves stages toward serial output
// R3: host sets data before shift clock rises
// R4: strobe high copies all stages into latches
// R5: latches stay transparent while strobe high
// R6: strobe low: latches hold their contents
// R7: enable low: outputs follow latch bits
// R8: enable high: all outputs forced low
// R9: enable never alters shift or latch
// R10: host keeps enable high when strobe tied
// R11: serial output shows last stage after edge
// R12: host waits 300 ns before strobe
// R13: host holds strobe high 100 ns minimum
// R14: host clock and data 150 ns minimum
`timescale 1ns/1ps
`include "sld_defines.vh"
module sld_driver #(
    parameter STAGES = `SLD_STAGES,
    parameter FIFO_DEPTH = `SLD_FIFO_DEPTH
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // serial link from the host
    input wire shiftClk,
    input wire serialIn,
    input wire strobe,
    input wire outEnableN,
    // chaining output
    output reg serialOut_r,
    // driver outputs
    output reg [STAGES-1:0] drvOut_r,
    // flow control and status
    input wire holdUpdate,
    output wire evtReady,
    output reg overflow_r
);
    reg shiftClkPrev_r;
    reg strobePrev_r;
    reg [STAGES-1:0] shift_r;
    reg [STAGES-1:0] latch_r;
    reg [STAGES-1:0] shiftNxt;
    reg [STAGES-1:0] latchNxt;
    wire shiftRise;
    wire strobeChange;
    wire pushValid;
    wire [`SLD_EVT_W-1:0] pushWord;
    wire popValid;
    wire popReady;
    wire [`SLD_EVT_W-1:0] popWord;
    wire popTake;

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    // rising level against the previous sample
    function isRise;
        input level;
        input prevLevel;
        begin
            isRise = level && !prevLevel;
        end
    endfunction

    // any level change against the previous sample
    function isChange;
        input level;
        input prevLevel;
        begin
            isChange = level != prevLevel;
        end
    endfunction

    // one place toward the serial output, new bit into the first stage
    function [STAGES-1:0] shiftIn;
        input [STAGES-1:0] stages;
        input bitIn;
        begin
            shiftIn = {stages[STAGES-2:0], bitIn};
        end
    endfunction

    // all outputs forced off while the enable is inactive
    function [STAGES-1:0] gateDrive;
        input [STAGES-1:0] bits;
        input enableN;
        begin
            if (enableN)
            begin
                gateDrive = `SLD_OUT_OFF;
            end
            else
            begin
                gateDrive = bits;
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // event capture on the link pins
    // ---------------------------------------------------------------
    // shift edge and strobe level travel in one word so their order holds
    assign shiftRise = isRise(shiftClk, shiftClkPrev_r); // R1
    assign strobeChange = isChange(strobe, strobePrev_r);
    assign pushValid = shiftRise || strobeChange;
    assign pushWord = {shiftRise, serialIn, strobe};

    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            shiftClkPrev_r <= 1'b0;
            strobePrev_r <= 1'b0;
        end
        else
        begin
            shiftClkPrev_r <= shiftClk;
            strobePrev_r <= strobe;
        end
    end

    // ---------------------------------------------------------------
    // overflow flag
    // ---------------------------------------------------------------
    // events arriving while full are lost and flagged
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            overflow_r <= 1'b0;
        end
        else if (pushValid && !evtReady)
        begin
            overflow_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // event fifo
    // ---------------------------------------------------------------
    sld_fifo #(
        .WIDTH(`SLD_EVT_W),
        .DEPTH(FIFO_DEPTH)
    ) sld_fifo_i (
        .core_clk(core_clk),
        .rstn(rstn),
        .inValid(pushValid),
        .inReady(evtReady),
        .inData(pushWord),
        .outValid(popValid),
        .outReady(popReady),
        .outData(popWord)
    );

    // ---------------------------------------------------------------
    // shift register and latch update
    // ---------------------------------------------------------------
    assign popReady = !holdUpdate;
    assign popTake = popValid && popReady;

    always @*
    begin
        shiftNxt = shift_r;
        if (popTake && popWord[`SLD_EVT_SHIFT])
        begin
            shiftNxt = shiftIn(shift_r, popWord[`SLD_EVT_DATA]); // R1 R2
        end
    end

    always @*
    begin
        latchNxt = latch_r; // R6
        if (popTake && popWord[`SLD_EVT_STB])
        begin
            latchNxt = shiftNxt; // R4 R5
        end
    end

    // ---------------------------------------------------------------
    // shift register and chaining output
    // ---------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            shift_r <= `SLD_SHIFT_RST;
            serialOut_r <= 1'b0;
        end
        else
        begin
            shift_r <= shiftNxt; // R9
            serialOut_r <= shiftNxt[STAGES-1]; // R11
        end
    end

    // ---------------------------------------------------------------
    // latches
    // ---------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            latch_r <= `SLD_LATCH_RST;
        end
        else
        begin
            latch_r <= latchNxt; // R9
        end
    end

    // ---------------------------------------------------------------
    // driver outputs
    // ---------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            drvOut_r <= `SLD_OUT_OFF;
        end
        else
        begin
            drvOut_r <= gateDrive(latchNxt, outEnableN); // R7 R8
        end
    end
endmodule

// ==== hw/sld_defines.vh ====
`ifndef SLD_DEFINES_VH
`define SLD_DEFINES_VH

// shift register and latch
`define SLD_STAGES 8
`define SLD_SHIFT_RST 8'h00
`define SLD_LATCH_RST 8'h00
`define SLD_OUT_OFF 8'h00

// event word carried through the fifo
`define SLD_EVT_W 3
`define SLD_EVT_SHIFT 2
`define SLD_EVT_DATA 1
`define SLD_EVT_STB 0
`define SLD_FIFO_DEPTH 32

// host timing, ns, and derived cycles at the core clock
`define SLD_CLK_NS 10
`define SLD_T_CLK2STB_NS 300
`define SLD_T_STBW_NS 100
`define SLD_T_PULSE_NS 150
`define SLD_CYC_CLK2STB ((`SLD_T_CLK2STB_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)
`define SLD_CYC_STBW ((`SLD_T_STBW_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)
`define SLD_CYC_PULSE ((`SLD_T_PULSE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS)

`endif

// ==== hw/sld_fifo.v ====
`timescale 1ns/1ps
module sld_fifo #(
    parameter WIDTH = 3,
    parameter DEPTH = 32
) (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // fill side
    input wire inValid,
    output reg inReady,
    input wire [WIDTH-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_r;
    reg [AW-1:0] rdPtr_r;
    reg [AW:0] count_r;
    wire doPush;
    wire doPop;

    // wrap-around step shared by both pointers
    function [AW-1:0] nextPtr;
        input [AW-1:0] ptr;
        begin
            if (ptr == DEPTH - 1)
            begin
                nextPtr = {AW{1'b0}};
            end
            else
            begin
                nextPtr = ptr + 1'b1;
            end
        end
    endfunction

    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_r];

    // ---------------------------------------------------------------
    // storage and pointers
    // ---------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (doPush)
        begin
            mem[wrPtr_r] <= inData;
        end
    end

    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            inReady <= 1'b1;
        end
        else
        begin
            if (doPush)
            begin
                wrPtr_r <= nextPtr(wrPtr_r);
            end
            if (doPop)
            begin
                rdPtr_r <= nextPtr(rdPtr_r);
            end
            if (doPush && !doPop)
            begin
                count_r <= count_r + 1'b1;
                inReady <= (count_r != DEPTH - 1);
            end
            else if (doPop && !doPush)
            begin
                count_r <= count_r - 1'b1;
                inReady <= 1'b1;
            end
        end
    end
endmodule

// ==== tb/sld_driver_properties.sv ====
`timescale 1ns/1ps
module sld_chk #(
    parameter STAGES = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // inputs
    input wire logic shiftClk,
    input wire logic serialIn,
    input wire logic strobe,
    input wire logic outEnableN,
    input wire logic holdUpdate,
    // outputs
    input wire logic serialOut_r,
    input wire logic [STAGES-1:0] drvOut_r,
    input wire logic evtReady,
    input wire logic overflow_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    oe_off_a: assert property (outEnableN |=> drvOut_r == '0)
        else $error("drive while disabled");
    hold_freeze_a: assert property (holdUpdate[*3] |-> $stable(serialOut_r))
        else $error("shift during hold");
    sout_cause_a: assert property ($changed(serialOut_r) |-> $past(shiftClk, 2))
        else $error("serial out moved alone");
    drv_cause_a: assert property ($changed(drvOut_r) |->
        $past(strobe, 2) || $past(outEnableN) != $past(outEnableN, 2))
        else $error("outputs moved alone");
    latch_copy_a: assert property (
        (strobe && !outEnableN && !holdUpdate)[*4] |-> drvOut_r[STAGES-1] == serialOut_r)
        else $error("latch not transparent");
    ovf_sticky_a: assert property (overflow_r |=> overflow_r)
        else $error("overflow lost");
    ovf_cause_a: assert property ($rose(overflow_r) |-> !$past(evtReady))
        else $error("overflow without full");
    full_stall_a: assert property (holdUpdate && !evtReady |=> !evtReady)
        else $error("full fifo drained in hold");
endmodule

bind sld_driver sld_chk #(.STAGES(STAGES)) sld_chk_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .shiftClk(shiftClk),
    .serialIn(serialIn),
    .strobe(strobe),
    .outEnableN(outEnableN),
    .holdUpdate(holdUpdate),
    .serialOut_r(serialOut_r),
    .drvOut_r(drvOut_r),
    .evtReady(evtReady),
    .overflow_r(overflow_r)
);

// ==== tb/sld_host.sv ====
`timescale 1ns/1ps
module sld_host (
    // clock
    input wire logic core_clk,
    // link
    output logic shiftClk,
    output logic serialIn,
    output logic strobe
);
    initial {shiftClk, serialIn, strobe} = 3'h0;
    task automatic shift_bit(input logic b);
        @(negedge core_clk) serialIn = b;
        repeat (8) @(negedge core_clk);
        shiftClk = 1'b1;
        repeat (8) @(negedge core_clk);
        serialIn = ~b;
        repeat (7) @(negedge core_clk);
        shiftClk = 1'b0;
        repeat (15) @(negedge core_clk);
    endtask
    task automatic latch_pulse();
        repeat (30) @(negedge core_clk);
        strobe = 1'b1;
        repeat (10) @(negedge core_clk);
        strobe = 1'b0;
    endtask
    task automatic set_stb(input logic v);
        @(negedge core_clk) strobe = v;
    endtask
endmodule

// ==== tb/tb_sld_driver.sv ====
`timescale 1ns/1ps
module tb_sld_driver;
    localparam logic [7:0] PAT = 8'ha5;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic outEnableN = 1'b0;
    logic holdUpdate = 1'b0;
    wire shiftClk, serialIn, strobe, serialOut_r, evtReady, overflow_r;
    wire [7:0] drvOut_r;
    int badCount = 0;
    int testsRun = 0;
    initial forever #5 core_clk = ~core_clk;
    sld_driver sld_driver_i (.core_clk(core_clk), .rstn(rstn), .shiftClk(shiftClk),
        .serialIn(serialIn), .strobe(strobe), .outEnableN(outEnableN),
        .serialOut_r(serialOut_r), .drvOut_r(drvOut_r), .holdUpdate(holdUpdate),
        .evtReady(evtReady), .overflow_r(overflow_r));
    sld_host sld_host_i (.core_clk(core_clk), .shiftClk(shiftClk), .serialIn(serialIn),
        .strobe(strobe));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            badCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finalReport();
        if (badCount == 0 && testsRun > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic t_shift_latch();
        for (int i = 7; i >= 0; i--)
            sld_host_i.shift_bit(PAT[i]);
        chk(drvOut_r, 8'h00);
        chk(8'(serialOut_r), 8'h01);
        sld_host_i.latch_pulse();
        chk(drvOut_r, PAT);
        outEnableN = 1'b1;
        wait_cyc(2);
        chk(drvOut_r, 8'h00);
        outEnableN = 1'b0;
        wait_cyc(2);
        chk(drvOut_r, PAT);
    endtask
    task automatic t_transp();
        sld_host_i.set_stb(1'b1);
        sld_host_i.shift_bit(1'b0);
        chk(drvOut_r, 8'h4a);
        sld_host_i.set_stb(1'b0);
        wait_cyc(4);
    endtask
    task automatic t_hold();
        holdUpdate = 1'b1;
        fork
            sld_host_i.shift_bit(1'b1);
            begin
                wait_cyc(14);
                chk(8'(serialOut_r), 8'h00);
                holdUpdate = 1'b0;
            end
        join
        chk(8'(serialOut_r), 8'h01);
    endtask
    task automatic t_tied();
        outEnableN = 1'b1;
        sld_host_i.set_stb(1'b1);
        sld_host_i.shift_bit(1'b1);
        sld_host_i.shift_bit(1'b0);
        chk(drvOut_r, 8'h00);
        chk(8'(serialOut_r), 8'h00);
        outEnableN = 1'b0;
        wait_cyc(2);
        chk(drvOut_r, 8'h56);
        sld_host_i.set_stb(1'b0);
        wait_cyc(4);
    endtask
    task automatic t_fill();
        outEnableN = 1'b1;
        holdUpdate = 1'b1;
        // 17 pulses give 34 strobe events against 32 fifo words
        repeat (17) sld_host_i.latch_pulse();
        chk({6'h00, evtReady, overflow_r}, 8'h01);
        holdUpdate = 1'b0;
        for (int i = 0; i < 100 && evtReady !== 1'b1; i++)
            wait_cyc(1);
        if (evtReady !== 1'b1)
        begin
            badCount++;
            finalReport();
        end
        wait_cyc(4);
        outEnableN = 1'b0;
        wait_cyc(2);
        chk(drvOut_r, 8'h56);
    endtask
    initial
    begin
        wait_cyc(6);
        rstn = 1'b1;
        wait_cyc(2);
        chk({5'h00, serialOut_r, evtReady, overflow_r}, 8'h02);
        t_shift_latch();
        t_transp();
        t_hold();
        t_tied();
        t_fill();
        finalReport();
    end
endmodule
